/* rtl/adgc_defines.svh */
`ifndef ADGC_DEFINES_SVH
`define ADGC_DEFINES_SVH

// Byte addresses of the register words (even byte = low byte)
`define ADGC_OFS_ADC        7'h0a
`define ADGC_OFS_DAC        7'h30
`define ADGC_OFS_PIN        7'h32
`define ADGC_OFS_MISC       7'h34
`define ADGC_OFS_CMD        7'h3e

// Command word fields
`define ADGC_CMD_LATCH      2

// Pin control fields
`define ADGC_PIN_DIR0       9
`define ADGC_PIN_DIR1       8
`define ADGC_PIN_LVL0       1
`define ADGC_PIN_LVL1       0

// Misc setup fields
`define ADGC_MISC_SELFTEST  8
`define ADGC_MISC_RDY_EN    2
`define ADGC_MISC_RDY_POL   1
`define ADGC_MISC_RDY_SEL   0

// Reset values and writable masks
`define ADGC_RST_DAC        12'h000
`define ADGC_RST_PIN        16'h0000
`define ADGC_RST_MISC       16'h0000
`define ADGC_RST_RDATA      16'h0000
`define ADGC_MASK_PIN       16'h0303
`define ADGC_MASK_MISC      16'h0107

`endif

/* rtl/adgc_pkg.sv */
package adgc_pkg;

  // One register access from the serial port front end
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } adgc_req_t;

  // Drive of one general-purpose pin
  typedef struct packed {
    logic level;
    logic enable;
  } adgc_drv_t;

  // Owner of a pin after arbitration
  typedef enum logic [2:0] {
    ADGC_OWN_READY = 3'b001,
    ADGC_OWN_ALARM = 3'b010,
    ADGC_OWN_PLAIN = 3'b100
  } adgc_owner_t;

endpackage

/* rtl/adgc_dac.sv */
`include "adgc_defines.svh"

module adgc_dac (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Holding register writes
  input  wire logic        wr_lo_in,
  input  wire logic        wr_hi_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        latch_in,
  // Results
  output logic      [11:0] hold_out,
  output logic      [11:0] code_out
);
  import adgc_pkg::*;

  logic [11:0] hold_ff;
  logic [11:0] code_ff;

  // Upper nibble of the high byte is dropped
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hold_ff <= `ADGC_RST_DAC;
    end else begin
      if (wr_lo_in) begin
        hold_ff[7:0] <= wdata_in;
      end
      if (wr_hi_in) begin
        hold_ff[11:8] <= wdata_in[3:0];
      end
    end
  end

  // Converter only moves on the latch command
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      code_ff <= `ADGC_RST_DAC;
    end else if (latch_in) begin
      code_ff <= hold_ff;
    end
  end

  assign hold_out = hold_ff;
  assign code_out = code_ff;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_dac_still;
    !latch_in |=> $stable(code_ff);
  endproperty
  a_dac_still: assert property (p_dac_still)
    else $error("converter code moved without latch");

  property p_dac_hi;
    wr_hi_in |=> hold_ff[11:8] == $past(wdata_in[3:0]);
  endproperty
  a_dac_hi: assert property (p_dac_hi)
    else $error("high byte not stored in holding bits 11:8");

endmodule

/* rtl/adgc_pins.sv */
`include "adgc_defines.svh"

module adgc_pins (
  // Clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    rst_in,
  // Control words
  input  wire logic             [15:0] pin_ctrl_in,
  input  wire logic             [15:0] misc_ctrl_in,
  // Competing functions
  input  wire logic             [1:0]  alarm_claim_in,
  input  wire logic             [1:0]  alarm_level_in,
  input  wire logic                    sample_ready_in,
  // Registered pin drive, index 0 is pin_zero
  output adgc_pkg::adgc_drv_t   [1:0]  drv_out
);
  import adgc_pkg::*;

  adgc_drv_t   [1:0] drv_ff;
  adgc_drv_t   [1:0] nxt_drv;
  adgc_owner_t [1:0] owner;

  function automatic adgc_owner_t pick_owner(input logic rdy_claim, input logic alm_claim);
    if (rdy_claim) begin
      pick_owner = ADGC_OWN_READY;
    end else if (alm_claim) begin
      pick_owner = ADGC_OWN_ALARM;
    end else begin
      pick_owner = ADGC_OWN_PLAIN;
    end
  endfunction

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      owner[i] = pick_owner(misc_ctrl_in[`ADGC_MISC_RDY_EN] &&
                            (misc_ctrl_in[`ADGC_MISC_RDY_SEL] == i[0]), alarm_claim_in[i]);
      case (owner[i])
        ADGC_OWN_READY: begin
          nxt_drv[i].enable = 1'b1;
          nxt_drv[i].level  = misc_ctrl_in[`ADGC_MISC_RDY_POL] ? sample_ready_in
                                                               : !sample_ready_in;
        end
        ADGC_OWN_ALARM: begin
          nxt_drv[i].enable = 1'b1;
          nxt_drv[i].level  = alarm_level_in[i];
        end
        default: begin
          nxt_drv[i].enable = pin_ctrl_in[`ADGC_PIN_DIR0 - i];
          nxt_drv[i].level  = pin_ctrl_in[`ADGC_PIN_DIR0 - i] &&
                              pin_ctrl_in[`ADGC_PIN_LVL0 - i];
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      drv_ff <= '0;
    end else begin
      drv_ff <= nxt_drv;
    end
  end

  assign drv_out = drv_ff;

endmodule

/* rtl/adgc_top.sv */
`include "adgc_defines.svh"

module adgc_top (
  // Clock and reset
  input  wire logic               MCLK_IN,
  input  wire logic               RST_IN,
  // Register access port
  input  wire adgc_pkg::adgc_req_t REG_REQ_IN,
  output logic             [15:0] REG_RDATA_OUT,
  output logic                    REG_RVALID_OUT,
  // Auxiliary converters
  input  wire logic        [11:0] ADC_RESULT_IN,
  output logic             [11:0] DAC_CODE_OUT,
  // Functions sharing the pins
  input  wire logic               SAMPLE_READY_IN,
  input  wire logic        [1:0]  ALARM_CLAIM_IN,
  input  wire logic        [1:0]  ALARM_LEVEL_IN,
  output logic                    SELF_TEST_OUT,
  // General-purpose pins
  input  wire logic               PIN_ZERO_IN,
  output logic                    PIN_ZERO_OUT,
  output logic                    PIN_ZERO_OE_OUT,
  input  wire logic               PIN_ONE_IN,
  output logic                    PIN_ONE_OUT,
  output logic                    PIN_ONE_OE_OUT
);
  import adgc_pkg::*;

  logic [15:0] pin_ctrl_ff;
  logic [15:0] misc_ff;
  logic [11:0] adc_result_ff;
  logic [1:0]  pin_sense_ff;
  logic [15:0] rdata_ff;
  logic        rvalid_ff;
  logic [15:0] nxt_rdata;
  logic [11:0] dac_hold;
  logic [11:0] dac_code;
  logic        wr_dac_lo;
  logic        wr_dac_hi;
  logic        dac_latch;
  adgc_drv_t [1:0] pin_drv;

  // Writable bits of each word, split per byte lane below
  localparam logic [15:0] pin_mask  = `ADGC_MASK_PIN;
  localparam logic [15:0] misc_mask = `ADGC_MASK_MISC;

  // Word match on the byte address, ignoring the byte select
  function automatic logic word_hit(input logic [6:0] addr, input logic [6:0] base);
    word_hit = (addr[6:1] == base[6:1]);
  endfunction

  // Write strobe for one byte lane of a word
  function automatic logic byte_wr(input adgc_req_t req, input logic [6:0] base, input logic hi);
    byte_wr = req.wr && word_hit(req.addr, base) && (req.addr[0] == hi);
  endfunction

  assign wr_dac_lo = byte_wr(REG_REQ_IN, `ADGC_OFS_DAC, 1'b0);
  assign wr_dac_hi = byte_wr(REG_REQ_IN, `ADGC_OFS_DAC, 1'b1);
  assign dac_latch = byte_wr(REG_REQ_IN, `ADGC_OFS_CMD, 1'b0) &&
                     REG_REQ_IN.wdata[`ADGC_CMD_LATCH];

  adgc_dac u_dac (
    .clk_in   (MCLK_IN),
    .rst_in   (RST_IN),
    .wr_lo_in (wr_dac_lo),
    .wr_hi_in (wr_dac_hi),
    .wdata_in (REG_REQ_IN.wdata),
    .latch_in (dac_latch),
    .hold_out (dac_hold),
    .code_out (dac_code)
  );

  // Pin control word, unused bits held at zero
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      pin_ctrl_ff <= `ADGC_RST_PIN;
    end else begin
      if (byte_wr(REG_REQ_IN, `ADGC_OFS_PIN, 1'b0)) begin
        pin_ctrl_ff[7:0] <= REG_REQ_IN.wdata & pin_mask[7:0];
      end
      if (byte_wr(REG_REQ_IN, `ADGC_OFS_PIN, 1'b1)) begin
        pin_ctrl_ff[15:8] <= REG_REQ_IN.wdata & pin_mask[15:8];
      end
    end
  end

  // Misc setup word: self-test and sample ready routing
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      misc_ff <= `ADGC_RST_MISC;
    end else begin
      if (byte_wr(REG_REQ_IN, `ADGC_OFS_MISC, 1'b0)) begin
        misc_ff[7:0] <= REG_REQ_IN.wdata & misc_mask[7:0];
      end
      if (byte_wr(REG_REQ_IN, `ADGC_OFS_MISC, 1'b1)) begin
        misc_ff[15:8] <= REG_REQ_IN.wdata & misc_mask[15:8];
      end
    end
  end

  // Converter result as seen by software, and pin levels sampled for the checks
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      adc_result_ff <= 12'h000;
      pin_sense_ff  <= 2'h0;
    end else begin
      adc_result_ff <= ADC_RESULT_IN;
      pin_sense_ff  <= {PIN_ONE_IN, PIN_ZERO_IN};
    end
  end

  // Read mux; unmapped and command addresses read zero
  always_comb begin
    nxt_rdata = 16'h0000;
    if (word_hit(REG_REQ_IN.addr, `ADGC_OFS_ADC)) begin
      nxt_rdata = {4'h0, adc_result_ff};
    end else if (word_hit(REG_REQ_IN.addr, `ADGC_OFS_DAC)) begin
      nxt_rdata = {4'h0, dac_hold};
    end else if (word_hit(REG_REQ_IN.addr, `ADGC_OFS_PIN)) begin
      nxt_rdata = pin_ctrl_ff;
    end else if (word_hit(REG_REQ_IN.addr, `ADGC_OFS_MISC)) begin
      nxt_rdata = misc_ff;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      rdata_ff  <= `ADGC_RST_RDATA;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= REG_REQ_IN.rd;
      if (REG_REQ_IN.rd) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  // Both pins resolved and registered together
  adgc_pins u_pins (
    .clk_in          (MCLK_IN),
    .rst_in          (RST_IN),
    .pin_ctrl_in     (pin_ctrl_ff),
    .misc_ctrl_in    (misc_ff),
    .alarm_claim_in  (ALARM_CLAIM_IN),
    .alarm_level_in  (ALARM_LEVEL_IN),
    .sample_ready_in (SAMPLE_READY_IN),
    .drv_out         (pin_drv)
  );

  assign REG_RDATA_OUT   = rdata_ff;
  assign REG_RVALID_OUT  = rvalid_ff;
  assign DAC_CODE_OUT    = dac_code;
  assign SELF_TEST_OUT   = misc_ff[`ADGC_MISC_SELFTEST];
  assign PIN_ZERO_OUT    = pin_drv[0].level;
  assign PIN_ZERO_OE_OUT = pin_drv[0].enable;
  assign PIN_ONE_OUT     = pin_drv[1].level;
  assign PIN_ONE_OE_OUT  = pin_drv[1].enable;

  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);

  logic rdy_on_zero;
  logic rdy_on_one;
  assign rdy_on_zero = misc_ff[`ADGC_MISC_RDY_EN] && !misc_ff[`ADGC_MISC_RDY_SEL];
  assign rdy_on_one  = misc_ff[`ADGC_MISC_RDY_EN] && misc_ff[`ADGC_MISC_RDY_SEL];

  // Valid is a single pulse unless another read follows
  property p_adc_read;
    REG_REQ_IN.rd && word_hit(REG_REQ_IN.addr, `ADGC_OFS_ADC)
      |=> REG_RVALID_OUT ##1 (REG_RVALID_OUT == $past(REG_REQ_IN.rd));
  endproperty
  a_adc_read: assert property (p_adc_read)
    else $error("converter result read gave no single valid pulse");

  property p_adc_value;
    REG_REQ_IN.rd && word_hit(REG_REQ_IN.addr, `ADGC_OFS_ADC)
      |=> REG_RVALID_OUT && REG_RDATA_OUT == {4'h0, $past(ADC_RESULT_IN, 2)};
  endproperty
  a_adc_value: assert property (p_adc_value)
    else $error("converter result read back wrong");

  property p_dac_hold_only;
    (wr_dac_lo || wr_dac_hi) && !dac_latch
      |=> DAC_CODE_OUT == $past(DAC_CODE_OUT);
  endproperty
  a_dac_hold_only: assert property (p_dac_hold_only)
    else $error("byte write reached the converter");

  property p_dac_latch;
    dac_latch |=> DAC_CODE_OUT == $past(dac_hold);
  endproperty
  a_dac_latch: assert property (p_dac_latch)
    else $error("latch command did not copy holding value");

  property p_dac_upper_zero;
    REG_REQ_IN.rd && word_hit(REG_REQ_IN.addr, `ADGC_OFS_DAC)
      |=> REG_RDATA_OUT[15:12] == 4'h0;
  endproperty
  a_dac_upper_zero: assert property (p_dac_upper_zero)
    else $error("holding bits 15:12 read nonzero");

  property p_dac_readback;
    wr_dac_lo ##1 !wr_dac_lo ##1 (REG_REQ_IN.rd && word_hit(REG_REQ_IN.addr, `ADGC_OFS_DAC) && !wr_dac_lo)
      |=> REG_RDATA_OUT[7:0] == $past(REG_REQ_IN.wdata, 3);
  endproperty
  a_dac_readback: assert property (p_dac_readback)
    else $error("holding low byte not read back");

  property p_reset_clear;
    disable iff (1'b0)
    RST_IN |=> pin_ctrl_ff == 16'h0000 && dac_hold == 12'h000 && !PIN_ZERO_OE_OUT
               ##1 !PIN_ZERO_OE_OUT || !RST_IN;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("reset left pin control or holding set");

  property p_ready_first;
    rdy_on_zero |=> PIN_ZERO_OE_OUT &&
      PIN_ZERO_OUT == ($past(misc_ff[`ADGC_MISC_RDY_POL]) ? $past(SAMPLE_READY_IN)
                                                          : !$past(SAMPLE_READY_IN));
  endproperty
  a_ready_first: assert property (p_ready_first)
    else $error("sample ready did not own pin zero");

  property p_ready_one;
    rdy_on_one && !ALARM_CLAIM_IN[1] && misc_ff[`ADGC_MISC_RDY_POL]
      |=> PIN_ONE_OE_OUT && PIN_ONE_OUT == $past(SAMPLE_READY_IN);
  endproperty
  a_ready_one: assert property (p_ready_one)
    else $error("active-high ready not on pin one");

  property p_alarm_second;
    !rdy_on_one && ALARM_CLAIM_IN[1]
      |=> PIN_ONE_OE_OUT && PIN_ONE_OUT == $past(ALARM_LEVEL_IN[1]);
  endproperty
  a_alarm_second: assert property (p_alarm_second)
    else $error("alarm did not own pin one");

  property p_dir_zero;
    !rdy_on_zero && !ALARM_CLAIM_IN[0]
      |=> PIN_ZERO_OE_OUT == $past(pin_ctrl_ff[`ADGC_PIN_DIR0]);
  endproperty
  a_dir_zero: assert property (p_dir_zero)
    else $error("pin zero direction not bit 9");

  property p_level_one;
    !rdy_on_one && !ALARM_CLAIM_IN[1] && pin_ctrl_ff[`ADGC_PIN_DIR1]
      |=> PIN_ONE_OE_OUT && PIN_ONE_OUT == $past(pin_ctrl_ff[`ADGC_PIN_LVL1]);
  endproperty
  a_level_one: assert property (p_level_one)
    else $error("pin one level not bit 0");

  property p_input_quiet;
    !rdy_on_one && !ALARM_CLAIM_IN[1] && !pin_ctrl_ff[`ADGC_PIN_DIR1]
      |=> !PIN_ONE_OE_OUT && !PIN_ONE_OUT;
  endproperty
  a_input_quiet: assert property (p_input_quiet)
    else $error("input pin one was driven");

  // Driven pin zero must read back its own level
  property p_pin_echo;
    PIN_ZERO_OE_OUT |=> pin_sense_ff[0] == $past(PIN_ZERO_OUT);
  endproperty
  a_pin_echo: assert property (p_pin_echo)
    else $error("driven pin zero level not seen at its input");

  property p_pin_write;
    byte_wr(REG_REQ_IN, `ADGC_OFS_PIN, 1'b1)
      |=> pin_ctrl_ff[9:8] == $past(REG_REQ_IN.wdata[1:0]) ##1 1'b1;
  endproperty
  a_pin_write: assert property (p_pin_write)
    else $error("pin direction write lost");

  property p_cov_latch;
    wr_dac_lo ##[1:4] wr_dac_hi ##[1:4] dac_latch;
  endproperty
  c_cov_latch: cover property (p_cov_latch);

  property p_cov_ready_one;
    rdy_on_one ##1 PIN_ONE_OE_OUT;
  endproperty
  c_cov_ready_one: cover property (p_cov_ready_one);

  property p_cov_alarm;
    ALARM_CLAIM_IN[0] && !rdy_on_zero ##1 PIN_ZERO_OE_OUT;
  endproperty
  c_cov_alarm: cover property (p_cov_alarm);

  property p_cov_pin_read;
    REG_REQ_IN.rd && word_hit(REG_REQ_IN.addr, `ADGC_OFS_PIN) ##1 REG_RDATA_OUT != 16'h0000;
  endproperty
  c_cov_pin_read: cover property (p_cov_pin_read);

endmodule

/* tb/adgc_host_model.sv */
module adgc_host_model (
  // Clock and answer
  input  wire logic                clk_in,
  input  wire logic         [15:0] rdata_in,
  input  wire logic                rvalid_in,
  // Request to the register port
  output adgc_pkg::adgc_req_t      req_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import adgc_pkg::*;

  initial req_out = '0;

  // One byte write, request held up to the taking edge
  task automatic wr_byte(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_in);
    req_out <= '{1'b1, 1'b0, a, d};
    @(posedge clk_in);
    req_out <= '0;
  endtask

  // Word read, answer sampled at the edge after the taking edge
  task automatic rd_word(input logic [6:0] a, output logic [15:0] d, output logic ok);
    @(posedge clk_in);
    req_out <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_in);
    req_out <= '0;
    @(posedge clk_in);
    ok = rvalid_in;
    d = rdata_in;
  endtask
endmodule

/* tb/adgc_top_bench.sv */
module adgc_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import adgc_pkg::*;

  logic               MCLK_IN;
  logic               RST_IN;
  adgc_req_t          req;
  logic        [15:0] rdata;
  logic               rvalid;
  logic        [11:0] adc;
  logic        [11:0] dac;
  logic               sr;
  logic        [1:0]  aclaim;
  logic        [1:0]  alvl;
  logic               st;
  logic               p0_out;
  logic               p0_oe;
  logic               p1_out;
  logic               p1_oe;
  wire logic          pin0;
  wire logic          pin1;
  int                 hold;
  int                 code;
  int                 pctl;
  int                 misc;
  int                 seed = 99862;
  int                 err_count = 0;
  int                 check_count = 0;
  logic        [6:0]  wa [8] = '{7'h30, 7'h31, 7'h32, 7'h33, 7'h34, 7'h35, 7'h3e, 7'h21};
  logic        [6:0]  ra [6] = '{7'h0a, 7'h30, 7'h32, 7'h34, 7'h3e, 7'h20};

  // Pins have a pull-up when nobody drives them
  assign pin0 = p0_oe ? p0_out : 1'b1;
  assign pin1 = p1_oe ? p1_out : 1'b1;

  adgc_top u_adgc_top (
    .MCLK_IN         (MCLK_IN),
    .RST_IN          (RST_IN),
    .REG_REQ_IN      (req),
    .REG_RDATA_OUT   (rdata),
    .REG_RVALID_OUT  (rvalid),
    .ADC_RESULT_IN   (adc),
    .DAC_CODE_OUT    (dac),
    .SAMPLE_READY_IN (sr),
    .ALARM_CLAIM_IN  (aclaim),
    .ALARM_LEVEL_IN  (alvl),
    .SELF_TEST_OUT   (st),
    .PIN_ZERO_IN     (pin0),
    .PIN_ZERO_OUT    (p0_out),
    .PIN_ZERO_OE_OUT (p0_oe),
    .PIN_ONE_IN      (pin1),
    .PIN_ONE_OUT     (p1_out),
    .PIN_ONE_OE_OUT  (p1_oe)
  );

  adgc_host_model u_adgc_host_model (
    .clk_in    (MCLK_IN),
    .rdata_in  (rdata),
    .rvalid_in (rvalid),
    .req_out   (req)
  );

  initial begin
    MCLK_IN = 1'b0;
    forever #50 MCLK_IN = ~MCLK_IN;
  end

  task automatic print_verdict;
    if (err_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic miss(input string m);
    err_count++;
    $display("wrong value at %0t: %s", $time, m);
  endtask

  task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp, input logic ok);
    check_count++;
    if (ok !== 1'b1 || got !== exp) begin
      miss($sformatf("read %h valid %b, expected %h", got, ok, exp));
    end
  endtask

  task automatic cmp_dac(input logic [11:0] got);
    check_count++;
    if (got !== code[11:0]) begin
      miss($sformatf("converter code %h, expected %h", got, code[11:0]));
    end
  endtask

  // Pin owner: sample ready, then alarm, then plain control
  function automatic logic [1:0] pin_exp(input int i);
    if (misc[2] && misc[0] == i) begin
      return {1'b1, misc[1] ? sr : ~sr};
    end
    if (aclaim[i]) begin
      return {1'b1, alvl[i]};
    end
    if (pctl[9 - i]) begin
      return {1'b1, pctl[1 - i]};
    end
    return 2'b00;
  endfunction

  task automatic cmp_pins(input logic [4:0] got);
    logic [4:0] exp;
    exp = {misc[8], pin_exp(1), pin_exp(0)};
    check_count++;
    if (got !== exp) begin
      miss($sformatf("self test and pins %b, expected %b", got, exp));
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_adgc_host_model.wr_byte(a, d);
    case (a)
      7'h30: hold = (hold & 12'hf00) | d;
      7'h31: hold = (hold & 12'h0ff) | ((d & 8'h0f) << 8);
      7'h32: pctl = (pctl & 16'h0300) | (d & 8'h03);
      7'h33: pctl = (pctl & 16'h0003) | ((d & 8'h03) << 8);
      7'h34: misc = (misc & 16'h0100) | (d & 8'h07);
      7'h35: misc = (misc & 16'h0007) | ((d & 8'h01) << 8);
      7'h3e: if (d[2]) code = hold;
      default: ;
    endcase
  endtask

  function automatic logic [15:0] model_rd(input logic [6:0] a);
    case (a)
      7'h0a:   return {4'h0, adc};
      7'h30:   return hold[15:0];
      7'h32:   return pctl[15:0];
      7'h34:   return misc[15:0];
      default: return 16'h0000;
    endcase
  endfunction

  task automatic check_all;
    logic [15:0] d;
    logic        ok;
    repeat (3) @(posedge MCLK_IN);
    cmp_dac(dac);
    cmp_pins({st, p1_oe, p1_out, p0_oe, p0_out});
    foreach (ra[i]) begin
      u_adgc_host_model.rd_word(ra[i], d, ok);
      cmp_reg(d, model_rd(ra[i]), ok);
    end
  endtask

  task automatic clear_model;
    hold = 0;
    code = 0;
    pctl = 0;
    misc = 0;
  endtask

  initial begin
    int          r;
    logic [15:0] d;
    logic        ok;
    RST_IN = 1'b1;
    adc = 12'h000;
    sr = 1'b0;
    aclaim = 2'b00;
    alvl = 2'b00;
    clear_model();
    repeat (5) @(posedge MCLK_IN);
    RST_IN <= 1'b0;
    @(posedge MCLK_IN);
    check_all();
    adc <= 12'hfff;
    wr(7'h30, 8'hff);
    wr(7'h31, 8'hff);
    wr(7'h30, 8'h5a);
    u_adgc_host_model.rd_word(7'h30, d, ok);
    cmp_reg(d, model_rd(7'h30), ok);
    check_all();
    wr(7'h3e, 8'h04);
    check_all();
    repeat (60) begin
      r = $random(seed);
      adc <= r[11:0];
      sr <= r[12];
      aclaim <= r[14:13];
      alvl <= r[16:15];
      wr(wa[r[19:17]], r[27:20]);
      check_all();
    end
    RST_IN <= 1'b1;
    repeat (5) @(posedge MCLK_IN);
    RST_IN <= 1'b0;
    clear_model();
    @(posedge MCLK_IN);
    check_all();
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge MCLK_IN);
    miss("timeout");
    print_verdict();
  end
endmodule
